// File: adc_cal_pkg.sv
package adc_cal_pkg;

    // register byte addresses
    localparam logic [31:0] TEMP_OFFSET_ADDR  = 32'h0000223C;
    localparam logic [31:0] GAIN9_GAIN_ADDR   = 32'h00002298;
    localparam logic [31:0] GAIN9_OFFSET_ADDR = 32'h000022D0;

    // calibration field layout
    localparam int          CAL_W      = 15;
    localparam int          CAL_MSB    = 14;
    localparam int          BUS_W      = 32;
    localparam int          RESULT_W   = 16;
    localparam int          SUM_W      = 20;
    localparam int          PROD_W     = 35;
    localparam int          GAIN_FRAC  = 14;
    localparam int          OFS_FRAC   = 2;
    localparam int          PROD_SHIFT = 16;

    // reset values and fixed codes
    localparam logic [14:0] GAIN_RESET   = 15'h4000;
    localparam logic [14:0] OFFSET_RESET = 15'h0000;
    localparam logic [14:0] GAIN_UNITY   = 15'h4000;
    localparam logic [14:0] GAIN_ILLEGAL = 15'h0000;
    localparam logic [15:0] RESULT_MAX   = 16'hFFFF;
    localparam logic [15:0] RESULT_ZERO  = 16'h0000;
    localparam logic [31:0] WORD_ZERO    = 32'h00000000;

    // ahb-lite encodings
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
    localparam logic        HRESP_OKAY = 1'h0;

    typedef enum logic [1:0]
    {
        CH_AUX  = 2'b00,
        CH_TIA  = 2'b01,
        CH_TEMP = 2'b10
    } chan_t;

    typedef enum logic [2:0]
    {
        PGA_1   = 3'b000,
        PGA_1P5 = 3'b001,
        PGA_2   = 3'b010,
        PGA_4   = 3'b011,
        PGA_9   = 3'b100
    } pga_t;

    typedef struct packed
    {
        chan_t         chan;
        pga_t          pga;
        logic [15:0]   data;
    } raw_sample_t;

    typedef struct packed
    {
        logic          temp_ofs;
        logic          aux_gain;
        logic          aux_ofs;
    } reg_sel_t;

endpackage : adc_cal_pkg

// File: adc_result_calibration_gain9_temp.sv
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/100ps

module adc_result_calibration_gain9_temp
    import adc_cal_pkg::*;
(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                srst,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // raw conversion from the adc datapath
    input  wire raw_sample_t         raw_sample,
    input  wire logic                raw_valid,
    // corrected conversion
    output logic      [15:0]         conversion_result_word,
    output logic                     result_valid
);

    // two's complement offset in quarter lsb, widened to the sum width
    function automatic logic signed [SUM_W-1:0] offset_ext(input logic [CAL_W-1:0] code);
        offset_ext = {{(SUM_W-CAL_W){code[CAL_MSB]}}, code};
    endfunction : offset_ext

    // drop quarter and gain fraction bits, saturate to the result range
    function automatic logic [RESULT_W-1:0] clamp_result(input logic signed [PROD_W-1:0] prod);
        logic signed [PROD_W-1:0] scaled;
        scaled = prod >>> PROD_SHIFT;
        if (scaled < 0)
        begin
            clamp_result = RESULT_ZERO;
        end
        else if (scaled > $signed({{(PROD_W-RESULT_W){1'b0}}, RESULT_MAX}))
        begin
            clamp_result = RESULT_MAX;
        end
        else
        begin
            clamp_result = scaled[RESULT_W-1:0];
        end
    endfunction : clamp_result

    // register select from a byte address, shared by the write and read paths
    function automatic reg_sel_t reg_decode(input logic [31:0] addr);
        reg_decode.aux_ofs  = (addr == GAIN9_OFFSET_ADDR);
        reg_decode.aux_gain = (addr == GAIN9_GAIN_ADDR);
        reg_decode.temp_ofs = (addr == TEMP_OFFSET_ADDR);
    endfunction : reg_decode

    // reserved upper bits always read back as zero
    function automatic logic [BUS_W-1:0] read_word(input logic [CAL_W-1:0] field);
        read_word = {{(BUS_W-CAL_W){1'b0}}, field};
    endfunction : read_word

    // register file
    logic [CAL_W-1:0]               aux_gain9_offset_cal_ff;
    logic [CAL_W-1:0]               aux_gain9_gain_cal_ff;
    logic [CAL_W-1:0]               temp_channel_offset_cal_ff;
    logic [CAL_W-1:0]               nxt_aux_gain9_offset_cal;
    logic [CAL_W-1:0]               nxt_aux_gain9_gain_cal;
    logic [CAL_W-1:0]               nxt_temp_channel_offset_cal;

    // bus state
    logic                           wr_pend_ff;
    logic [31:0]                    wr_addr_ff;
    logic [31:0]                    hrdata_ff;
    logic                           hreadyout_ff;
    logic                           hresp_ff;
    logic                           addr_take;
    logic [31:0]                    nxt_rdata;
    reg_sel_t                       wr_sel;
    reg_sel_t                       rd_sel;

    // datapath
    logic signed [SUM_W-1:0]        sum_ff;
    logic [CAL_W-1:0]               gain_ff;
    logic                           stage_valid_ff;
    logic [RESULT_W-1:0]            result_ff;
    logic                           result_valid_ff;
    logic                           apply_aux;
    logic                           apply_temp;
    logic signed [SUM_W-1:0]        nxt_sum;
    logic [CAL_W-1:0]               nxt_gain;
    logic signed [PROD_W-1:0]       product;

    assign addr_take = hsel & hready & htrans[1];

    // address phase capture
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_pend_ff <= 1'b0;
        end
        else
        begin
            wr_pend_ff <= addr_take & hwrite & (hsize == HSIZE_WORD);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_addr_ff <= WORD_ZERO;
        end
        else
        begin
            wr_addr_ff <= haddr;
        end
    end

    // data phase write, only the 15-bit value field is kept
    always_comb
    begin
        wr_sel                      = reg_decode(wr_addr_ff);
        nxt_aux_gain9_offset_cal    = aux_gain9_offset_cal_ff;
        nxt_aux_gain9_gain_cal      = aux_gain9_gain_cal_ff;
        nxt_temp_channel_offset_cal = temp_channel_offset_cal_ff;
        if (wr_pend_ff && wr_sel.aux_ofs)
        begin
            nxt_aux_gain9_offset_cal = hwdata[CAL_W-1:0];
        end
        if (wr_pend_ff && wr_sel.aux_gain)
        begin
            nxt_aux_gain9_gain_cal = hwdata[CAL_W-1:0];
        end
        if (wr_pend_ff && wr_sel.temp_ofs)
        begin
            nxt_temp_channel_offset_cal = hwdata[CAL_W-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            aux_gain9_offset_cal_ff <= OFFSET_RESET;
        end
        else
        begin
            aux_gain9_offset_cal_ff <= nxt_aux_gain9_offset_cal;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            aux_gain9_gain_cal_ff <= GAIN_RESET;
        end
        else
        begin
            aux_gain9_gain_cal_ff <= nxt_aux_gain9_gain_cal;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            temp_channel_offset_cal_ff <= OFFSET_RESET;
        end
        else
        begin
            temp_channel_offset_cal_ff <= nxt_temp_channel_offset_cal;
        end
    end

    // read mux uses next values so a read right after a write sees it
    always_comb
    begin
        rd_sel    = reg_decode(haddr);
        nxt_rdata = WORD_ZERO;
        if (rd_sel.aux_ofs)
        begin
            nxt_rdata = read_word(nxt_aux_gain9_offset_cal);
        end
        else if (rd_sel.aux_gain)
        begin
            nxt_rdata = read_word(nxt_aux_gain9_gain_cal);
        end
        else if (rd_sel.temp_ofs)
        begin
            nxt_rdata = read_word(nxt_temp_channel_offset_cal);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            hrdata_ff <= WORD_ZERO;
        end
        else if (addr_take & ~hwrite)
        begin
            hrdata_ff <= nxt_rdata;
        end
        else
        begin
            hrdata_ff <= WORD_ZERO;
        end
    end

    // zero wait state, always okay
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            hreadyout_ff <= 1'b1;
        end
        else
        begin
            hreadyout_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            hresp_ff <= HRESP_OKAY;
        end
        else
        begin
            hresp_ff <= HRESP_OKAY;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    // stage 1: select the calibration set
    always_comb
    begin
        apply_aux  = (raw_sample.chan == CH_AUX) && (raw_sample.pga == PGA_9);
        apply_temp = (raw_sample.chan == CH_TEMP);
    end

    // offset is added before any scaling; sum width covers full scale plus largest offset
    always_comb
    begin
        nxt_sum = $signed({{(SUM_W-RESULT_W-OFS_FRAC){1'b0}}, raw_sample.data, {OFS_FRAC{1'b0}}});
        if (apply_aux)
        begin
            nxt_sum = nxt_sum + offset_ext(aux_gain9_offset_cal_ff);
        end
        else if (apply_temp)
        begin
            nxt_sum = nxt_sum + offset_ext(temp_channel_offset_cal_ff);
        end
    end

    // only aux channels at gain 9 are scaled
    always_comb
    begin
        nxt_gain = GAIN_UNITY;
        if (apply_aux)
        begin
            nxt_gain = aux_gain9_gain_cal_ff;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            stage_valid_ff <= 1'b0;
        end
        else
        begin
            stage_valid_ff <= raw_valid;
        end
    end

    // calibration set is frozen with the sample it belongs to
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sum_ff  <= '0;
            gain_ff <= GAIN_UNITY;
        end
        else if (raw_valid)
        begin
            sum_ff  <= nxt_sum;
            gain_ff <= nxt_gain;
        end
    end

    // stage 2: gain is unsigned 1.14, code 0x4000 is unity
    assign product = sum_ff * $signed({{(PROD_W-CAL_W){1'b0}}, gain_ff});

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            result_valid_ff <= 1'b0;
        end
        else
        begin
            result_valid_ff <= stage_valid_ff;
        end
    end

    // the word holds between results
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            result_ff <= RESULT_ZERO;
        end
        else if (stage_valid_ff && (gain_ff == GAIN_ILLEGAL))
        begin
            result_ff <= RESULT_ZERO;
        end
        else if (stage_valid_ff)
        begin
            result_ff <= clamp_result(product);
        end
    end

    assign conversion_result_word = result_ff;
    assign result_valid           = result_valid_ff;

endmodule : adc_result_calibration_gain9_temp

// File: adc_cal_asserts.sv
`timescale 1ns/100ps
module adc_cal_checker
    import adc_cal_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // sample path
    input wire raw_sample_t raw_sample,
    input wire logic        raw_valid,
    input wire logic [15:0] conversion_result_word,
    input wire logic        result_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    function automatic logic mapped(logic [31:0] a);
        return a == TEMP_OFFSET_ADDR || a == GAIN9_GAIN_ADDR || a == GAIN9_OFFSET_ADDR;
    endfunction : mapped
    sequence s_read;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_write;
        hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD && mapped(haddr);
    endsequence
    sequence s_pass;
        raw_valid && (raw_sample.chan == CH_TIA || (raw_sample.chan == CH_AUX && raw_sample.pga != PGA_9));
    endsequence
    a_result_latency: assert property (raw_valid |-> ##2 result_valid)
        else $error("result pulse missing two cycles after sample");
    a_result_cause: assert property (result_valid |-> $past(raw_valid, 2))
        else $error("result pulse without sample");
    a_pass_through: assert property (s_pass |-> ##2 conversion_result_word == $past(raw_sample.data, 2))
        else $error("uncorrected channel altered");
    a_word_hold: assert property (!result_valid |-> $stable(conversion_result_word))
        else $error("result word changed without pulse");
    a_reserved_zero: assert property (hrdata[31:15] == 17'h0)
        else $error("upper read bits not zero");
    a_unmapped_zero: assert property (s_read ##0 !mapped(haddr) |=> hrdata == WORD_ZERO)
        else $error("unmapped read not zero");
    a_idle_zero: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == WORD_ZERO)
        else $error("read data outside read phase");
    a_write_readback: assert property (s_write ##1 (s_read ##0 haddr == $past(haddr)) |=> hrdata[14:0] == $past(hwdata[14:0]))
        else $error("read after write mismatch");
endmodule : adc_cal_checker
bind adc_result_calibration_gain9_temp adc_cal_checker i_adc_cal_checker (.mclk, .srst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .raw_sample, .raw_valid, .conversion_result_word, .result_valid);

// File: adc_cal_tb.sv
`timescale 1ns/100ps
module adc_result_calibration_gain9_temp_test;
    import adc_cal_pkg::*;
    logic        mclk, srst, hsel, hwrite, raw_valid;
    logic [31:0] haddr, hwdata, q, wd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    raw_sample_t raw_sample;
    wire  [31:0] hrdata;
    wire         hready, hreadyout, hresp, result_valid;
    wire  [15:0] conversion_result_word;
    logic [14:0] aofs, gn, tofs;
    logic [15:0] exp_q[$];
    logic [31:0] regs[3] = '{TEMP_OFFSET_ADDR, GAIN9_GAIN_ADDR, GAIN9_OFFSET_ADDR};
    logic [31:0] rst_v[3] = '{32'h0, 32'h4000, 32'h0};
    logic [14:0] ao_t[5] = '{15'h0000, 15'h3FFF, 15'h4000, 15'h7FFF, 15'h0001};
    logic [14:0] gn_t[5] = '{15'h4000, 15'h7FFF, 15'h2000, 15'h4001, 15'h0000};
    logic [14:0] to_t[5] = '{15'h0000, 15'h4000, 15'h7FFF, 15'h0001, 15'h3FFF};
    int          num_errors, cmp_count, cyc;
    chan_t       c;
    pga_t        p;
    assign hready = hreadyout;
    adc_result_calibration_gain9_temp i_adc_result_calibration_gain9_temp (.mclk, .srst, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .raw_sample, .raw_valid,
        .conversion_result_word, .result_valid);
    initial
    begin
        mclk = 0;
        forever #20 mclk = ~mclk;
    end
    task automatic wrap_up();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one single transfer; entered and left right after a rising edge
    task automatic bus(input logic w, input logic [31:0] a, d, input logic [2:0] sz, output logic [31:0] r);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= sz;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
        check(hresp, HRESP_OKAY);
    endtask : bus
    // write, then a read of the same word whose address phase overlaps the write data phase
    task automatic wr_rd(input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= 1;
        hsize <= HSIZE_WORD;
        do @(posedge mclk); while (hready !== 1'b1);
        hwrite <= 0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 0;
        htrans <= 2'b00;
        do @(posedge mclk); while (hready !== 1'b1);
        r = hrdata;
        check(hresp, HRESP_OKAY);
    endtask : wr_rd
    function automatic longint sx(logic [14:0] v);
        return v[14] ? longint'(v) - 32768 : longint'(v);
    endfunction : sx
    function automatic logic [15:0] exp_res(chan_t ch, pga_t pg, logic [15:0] d);
        longint s;
        longint g;
        g = 16384;
        if (ch == CH_AUX && pg == PGA_9)
        begin
            s = 4 * longint'(d) + sx(aofs);
            g = longint'(gn);
        end
        else if (ch == CH_TEMP)
            s = 4 * longint'(d) + sx(tofs);
        else
            return d;
        s = (s * g) >>> 16;
        return s < 0 ? 16'h0000 : (s > 65535 ? 16'hFFFF : s[15:0]);
    endfunction : exp_res
    always @(negedge mclk)
        if (!srst && result_valid === 1'b1)
            check(conversion_result_word, exp_q.size() ? exp_q.pop_front() : 32'h10000);
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    initial
    begin
        srst = 1;
        hsel = 0;
        haddr = 0;
        htrans = 0;
        hwrite = 0;
        hsize = HSIZE_WORD;
        hwdata = 0;
        raw_valid = 0;
        raw_sample = '0;
        num_errors = 0;
        cmp_count = 0;
        void'($urandom(32'h143C9DD6));
        repeat (8) @(posedge mclk);
        srst <= 0;
        @(posedge mclk);
        foreach (regs[i])
        begin
            bus(0, regs[i], 0, HSIZE_WORD, q);
            check(q, rst_v[i]);
            bus(1, regs[i], 32'hFFFFFFFF, HSIZE_WORD, q);
            bus(0, regs[i], 0, HSIZE_WORD, q);
            check(q, 32'h7FFF);
            bus(1, regs[i], 32'h1, 3'h0, q);
            bus(0, regs[i], 0, HSIZE_WORD, q);
            check(q, 32'h7FFF);
        end
        bus(0, 32'h22D4, 0, HSIZE_WORD, q);
        check(q, 32'h0);
        foreach (regs[i])
        begin
            wd = $urandom;
            wr_rd(regs[i], wd, q);
            check(q, {17'h0, wd[14:0]});
        end
        for (int i = 0; i < 10; i++)
        begin
            aofs = i < 5 ? ao_t[i] : 15'($urandom);
            gn = i < 5 ? gn_t[i] : 15'($urandom);
            tofs = i < 5 ? to_t[i] : 15'($urandom);
            bus(1, GAIN9_OFFSET_ADDR, {17'($urandom), aofs}, HSIZE_WORD, q);
            bus(1, GAIN9_GAIN_ADDR, {17'($urandom), gn}, HSIZE_WORD, q);
            bus(1, TEMP_OFFSET_ADDR, {17'($urandom), tofs}, HSIZE_WORD, q);
            for (int k = 0; k < 40; k++)
            begin
                c = chan_t'($urandom_range(2));
                p = $urandom_range(1) ? PGA_9 : pga_t'($urandom_range(4));
                raw_sample <= '{c, p, k < 2 ? {16{k[0]}} : 16'($urandom)};
                raw_valid <= k < 4 ? 1'b1 : 1'($urandom);
                @(posedge mclk);
                if (raw_valid)
                    exp_q.push_back(exp_res(raw_sample.chan, raw_sample.pga, raw_sample.data));
            end
            raw_valid <= 0;
            repeat (3) @(posedge mclk);
        end
        check(exp_q.size(), 0);
        srst <= 1;
        repeat (2) @(posedge mclk);
        srst <= 0;
        @(posedge mclk);
        foreach (regs[i])
        begin
            bus(0, regs[i], 0, HSIZE_WORD, q);
            check(q, rst_v[i]);
        end
        wrap_up();
    end
endmodule : adc_result_calibration_gain9_temp_test
